// File: rtl/sensor_interrupt_logic.sv
// Interrupt flags, FIFO occupancy, register file and two interrupt pins
// What this block does
// - Each source routes to pin A, pin B or both via per-pin route register.
// - A pin carries the OR of all flags routed to it.
// - Pin with nothing routed is released; both pins released after reset.
// - Asserted pin drives high, or low when its polarity bit is set.
// - Reading the flags register clears motion and stillness flags.
// - Reading any sample register clears the new-sample flag.
// - FIFO flags clear once enough FIFO data is read.
// - External clock select makes pin A an input, no interrupts there.
// - Sync trigger enable makes pin B the sample trigger input.
// - A pin in alternate use never signals; both may be alternate together.
// - Motion sets flag bit 4, stillness sets flag bit 5.
// - Bit 0 is set while a new sample is available.
// - New-sample flag stays clear during a sample read, set after it if a sample arrived meanwhile.
// - New-sample flag clears at the start of a sample register read.
// - Bit 2 is set while FIFO count reaches the nine-bit threshold.
// - Zero threshold keeps watermark set while FIFO is on; level register resets to 0x80.
// - Bit 1 is set while the FIFO holds at least one item.
// - Bit 3 sets when an item is pushed into a full FIFO.
// - Overrun clears when FIFO is read and whenever FIFO is disabled.
// - Each read FIFO item frees exactly one item of space.
// - FIFO mode 0b00 disables FIFO, clears content and FIFO flags.
`timescale 1ns/100ps
`include "sensor_irq_regs.svh"
module sensor_interrupt_logic
    import sensor_irq_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire byte_type i_reg_addr,
    input wire logic i_reg_wr,
    input wire byte_type i_reg_wdata,
    input wire logic i_rd_start,
    input wire logic i_rd_end,
    input wire logic i_motion_evt,
    input wire logic i_stillness_evt,
    input wire logic i_sample_evt,
    input wire logic i_fifo_push,
    input wire logic i_fifo_pop,
    input wire logic i_irq_pin_a,
    input wire logic i_irq_pin_b,
    output byte_type o_rd_data,
    output byte_type o_flags,
    output fifo_cnt_type o_fifo_count,
    output logic [1:0] o_fifo_mode,
    output logic o_irq_pin_a,
    output logic o_irq_pin_a_oe,
    output logic o_irq_pin_b,
    output logic o_irq_pin_b_oe,
    output logic o_ext_clock_in,
    output logic o_sync_trigger_in
);
    byte_type fifo_control_ff;
    byte_type fifo_watermark_level_ff;
    byte_type pin_a_route_reg_ff;
    byte_type pin_b_route_reg_ff;
    byte_type filter_control_reg_ff;
    byte_type power_control_reg_ff;

    logic new_sample_ff;
    logic sample_pend_ff;
    logic fifo_ready_ff;
    logic wmark_ff;
    logic overrun_ff;
    logic motion_detected_flag_ff;
    logic stillness_detected_flag_ff;
    fifo_cnt_type fifo_count_ff;
    fifo_cnt_type nxt_fifo_count;
    rd_state_type rd_state_ff;

    logic fifo_on;
    logic fifo_full;
    logic push_ok;
    logic pop_ok;
    logic start_flags_rd;
    logic start_sample_rd;
    logic ext_clock_select;
    logic sync_trigger_enable;
    threshold_type wmark_threshold;
    logic [`SRC_COUNT-1:0] src_flags;
    byte_type flag_byte;

    function automatic logic is_sample_addr(input byte_type a);
        is_sample_addr =
            (a >= `SAMPLE_LO_FIRST_ADDR && a <= `SAMPLE_LO_LAST_ADDR) ||
            (a >= `SAMPLE_HI_FIRST_ADDR && a <= `SAMPLE_HI_LAST_ADDR);
    endfunction : is_sample_addr

    assign fifo_on = fifo_control_ff[1:0] != `FIFO_MODE_OFF;
    assign fifo_full = fifo_count_ff == `FIFO_DEPTH;
    assign pop_ok = i_fifo_pop && fifo_count_ff != 10'h000;
    assign push_ok = i_fifo_push && fifo_on;
    assign start_flags_rd = i_rd_start && i_reg_addr == `FLAGS_ADDR;
    assign start_sample_rd = i_rd_start && is_sample_addr(i_reg_addr);
    assign ext_clock_select = power_control_reg_ff[`EXT_CLOCK_SELECT_BIT];
    assign sync_trigger_enable = filter_control_reg_ff[`SYNC_TRIGGER_BIT];
    assign wmark_threshold = {fifo_control_ff[`THRESHOLD_MSB_BIT],
                              fifo_watermark_level_ff};
    assign src_flags = {stillness_detected_flag_ff, motion_detected_flag_ff,
                        overrun_ff, wmark_ff, fifo_ready_ff, new_sample_ff};
    assign flag_byte = {2'b00, src_flags};

    // Writable configuration registers
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            fifo_control_ff <= `BYTE_RESET;
            fifo_watermark_level_ff <= `WMARK_LEVEL_RESET;
            pin_a_route_reg_ff <= `BYTE_RESET;
            pin_b_route_reg_ff <= `BYTE_RESET;
            filter_control_reg_ff <= `BYTE_RESET;
            power_control_reg_ff <= `BYTE_RESET;
        end
        else if (i_clk_en && i_reg_wr)
        begin
            case (i_reg_addr)
                `FIFO_CONTROL_ADDR: fifo_control_ff <= i_reg_wdata;
                `WMARK_LEVEL_ADDR: fifo_watermark_level_ff <= i_reg_wdata;
                `PIN_A_ROUTE_ADDR: pin_a_route_reg_ff <= i_reg_wdata;
                `PIN_B_ROUTE_ADDR: pin_b_route_reg_ff <= i_reg_wdata;
                `FILTER_CONTROL_ADDR: filter_control_reg_ff <= i_reg_wdata;
                `POWER_CONTROL_ADDR: power_control_reg_ff <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data is latched at the start of a read, before any clearing
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            o_rd_data <= `BYTE_RESET;
        else if (i_clk_en && i_rd_start)
        begin
            case (i_reg_addr)
                `FLAGS_ADDR: o_rd_data <= flag_byte;
                `FIFO_CONTROL_ADDR: o_rd_data <= fifo_control_ff;
                `WMARK_LEVEL_ADDR: o_rd_data <= fifo_watermark_level_ff;
                `PIN_A_ROUTE_ADDR: o_rd_data <= pin_a_route_reg_ff;
                `PIN_B_ROUTE_ADDR: o_rd_data <= pin_b_route_reg_ff;
                `FILTER_CONTROL_ADDR: o_rd_data <= filter_control_reg_ff;
                `POWER_CONTROL_ADDR: o_rd_data <= power_control_reg_ff;
                default: o_rd_data <= `BYTE_RESET;
            endcase
        end
    end

    // Motion flags: an event in the clearing cycle survives the read
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            motion_detected_flag_ff <= 1'b0;
            stillness_detected_flag_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (i_motion_evt)
                motion_detected_flag_ff <= 1'b1;
            else if (start_flags_rd)
                motion_detected_flag_ff <= 1'b0;
            if (i_stillness_evt)
                stillness_detected_flag_ff <= 1'b1;
            else if (start_flags_rd)
                stillness_detected_flag_ff <= 1'b0;
        end
    end

    // Read tracking, so a sample arriving mid-read is held back
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            rd_state_ff <= RD_IDLE;
        else if (i_clk_en)
        begin
            case (rd_state_ff)
                RD_IDLE, RD_OTHER:
                begin
                    if (start_sample_rd)
                        rd_state_ff <= RD_SAMPLE;
                    else if (i_rd_start)
                        rd_state_ff <= RD_OTHER;
                    else if (i_rd_end)
                        rd_state_ff <= RD_IDLE;
                end
                RD_SAMPLE:
                begin
                    if (i_rd_end)
                        rd_state_ff <= RD_IDLE;
                end
                default: rd_state_ff <= RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            new_sample_ff <= 1'b0;
            sample_pend_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (rd_state_ff == RD_SAMPLE)
            begin
                if (i_rd_end)
                begin
                    new_sample_ff <= sample_pend_ff | i_sample_evt;
                    sample_pend_ff <= 1'b0;
                end
                else if (i_sample_evt)
                    sample_pend_ff <= 1'b1;
            end
            else if (start_sample_rd)
            begin
                new_sample_ff <= 1'b0;
                sample_pend_ff <= i_sample_evt;
            end
            else if (i_sample_evt)
                new_sample_ff <= 1'b1;
        end
    end

    // Occupancy counts single data items, not whole sample sets
    always_comb
    begin
        nxt_fifo_count = fifo_count_ff;
        if (!fifo_on)
            nxt_fifo_count = 10'h000;
        else if (pop_ok && !push_ok)
            nxt_fifo_count = fifo_count_ff - 10'h001;
        else if (push_ok && !pop_ok && !fifo_full)
            nxt_fifo_count = fifo_count_ff + 10'h001;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            fifo_count_ff <= 10'h000;
        else if (i_clk_en)
            fifo_count_ff <= nxt_fifo_count;
    end

    // Level flags track the next count so they never lag the count output
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            fifo_ready_ff <= 1'b0;
            wmark_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            fifo_ready_ff <= nxt_fifo_count != 10'h000;
            wmark_ff <= fifo_on &&
                nxt_fifo_count >= {1'b0, wmark_threshold};
        end
    end

    // Overrun: stream mode replaces the oldest item, oldest-saved drops
    // the new one; both lose data, so both raise the flag
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            overrun_ff <= 1'b0;
        else if (i_clk_en)
        begin
            if (!fifo_on)
                overrun_ff <= 1'b0;
            else if (push_ok && fifo_full && !pop_ok)
                overrun_ff <= 1'b1;
            else if (pop_ok)
                overrun_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_flags <= `BYTE_RESET;
            o_fifo_count <= 10'h000;
            o_fifo_mode <= `FIFO_MODE_OFF;
        end
        else if (i_clk_en)
        begin
            o_flags <= flag_byte;
            o_fifo_count <= fifo_count_ff;
            o_fifo_mode <= fifo_control_ff[1:0];
        end
    end

    irq_pin_driver u_pin_a (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_flags(src_flags),
        .i_route(pin_a_route_reg_ff),
        .i_alt_sel(ext_clock_select),
        .i_pin(i_irq_pin_a),
        .o_pin(o_irq_pin_a),
        .o_pin_oe(o_irq_pin_a_oe),
        .o_alt_in(o_ext_clock_in)
    );

    irq_pin_driver u_pin_b (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_flags(src_flags),
        .i_route(pin_b_route_reg_ff),
        .i_alt_sel(sync_trigger_enable),
        .i_pin(i_irq_pin_b),
        .o_pin(o_irq_pin_b),
        .o_pin_oe(o_irq_pin_b_oe),
        .o_alt_in(o_sync_trigger_in)
    );

    property p_flags_read_clear;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && start_flags_rd && !i_motion_evt) |=>
            !motion_detected_flag_ff;
    endproperty
    a_flags_read_clear: assert property (p_flags_read_clear)
        else $error("motion flag survived a flags read");

    property p_sample_start_clear;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && start_sample_rd && rd_state_ff != RD_SAMPLE) |=>
            (!new_sample_ff && rd_state_ff == RD_SAMPLE);
    endproperty
    a_sample_start_clear: assert property (p_sample_start_clear)
        else $error("new-sample flag not cleared at read start");

    property p_sample_hold;
        @(posedge i_ref_clk) disable iff (i_rst)
        (rd_state_ff == RD_SAMPLE && !i_rd_end) |=> !new_sample_ff;
    endproperty
    a_sample_hold: assert property (p_sample_hold)
        else $error("new-sample flag set during a sample read");

    property p_wmark_level;
        @(posedge i_ref_clk) disable iff (i_rst)
        i_clk_en |=> (wmark_ff == ($past(fifo_on) &&
            fifo_count_ff >= {1'b0, $past(wmark_threshold)}));
    endproperty
    a_wmark_level: assert property (p_wmark_level)
        else $error("watermark flag disagrees with count");

    property p_ready_level;
        @(posedge i_ref_clk) disable iff (i_rst)
        fifo_ready_ff == (fifo_count_ff != 10'h000);
    endproperty
    a_ready_level: assert property (p_ready_level)
        else $error("fifo ready flag disagrees with count");

    property p_overrun_set;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && fifo_on && i_fifo_push && !i_fifo_pop && fifo_full)
            |=> (overrun_ff && fifo_count_ff == `FIFO_DEPTH);
    endproperty
    a_overrun_set: assert property (p_overrun_set)
        else $error("push into full fifo did not raise overrun");

    property p_disable_clears;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && !fifo_on) |=>
            (fifo_count_ff == 10'h000 && !overrun_ff && !wmark_ff);
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("disabled fifo kept content or flags");

    property p_pop_one;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && fifo_on && pop_ok && !i_fifo_push) |=>
            (fifo_count_ff == $past(fifo_count_ff) - 10'h001);
    endproperty
    a_pop_one: assert property (p_pop_one)
        else $error("fifo read freed other than one item");
endmodule : sensor_interrupt_logic

// File: pkg/sensor_irq_regs.svh
// Register offsets, field positions, reset values and sizes of the interrupt block
`ifndef SENSOR_IRQ_REGS_SVH
`define SENSOR_IRQ_REGS_SVH

`define SAMPLE_LO_FIRST_ADDR 8'h08
`define SAMPLE_LO_LAST_ADDR 8'h0a
`define FLAGS_ADDR 8'h0b
`define SAMPLE_HI_FIRST_ADDR 8'h0e
`define SAMPLE_HI_LAST_ADDR 8'h15
`define FIFO_CONTROL_ADDR 8'h28
`define WMARK_LEVEL_ADDR 8'h29
`define PIN_A_ROUTE_ADDR 8'h2a
`define PIN_B_ROUTE_ADDR 8'h2b
`define FILTER_CONTROL_ADDR 8'h2c
`define POWER_CONTROL_ADDR 8'h2d

`define FLAG_NEW_SAMPLE 0
`define FLAG_FIFO_READY 1
`define FLAG_WMARK 2
`define FLAG_OVERRUN 3
`define FLAG_MOTION 4
`define FLAG_STILLNESS 5
`define SRC_COUNT 6

`define ROUTE_POLARITY_BIT 7
`define THRESHOLD_MSB_BIT 3
`define SYNC_TRIGGER_BIT 3
`define EXT_CLOCK_SELECT_BIT 6

`define FIFO_MODE_OFF 2'b00
`define FIFO_MODE_OLDEST 2'b01
`define FIFO_DEPTH 10'h200

`define WMARK_LEVEL_RESET 8'h80
`define BYTE_RESET 8'h00

`endif

// File: pkg/sensor_irq_pkg.sv
// Types shared by the interrupt block and its pin driver
package sensor_irq_pkg;
    typedef logic [7:0] byte_type;
    typedef logic [9:0] fifo_cnt_type;
    typedef logic [8:0] threshold_type;
    typedef enum {RD_IDLE, RD_SAMPLE, RD_OTHER} rd_state_type;
endpackage : sensor_irq_pkg

// File: rtl/irq_pin_driver.sv
// One interrupt pin: routing, OR combine, polarity, release and alternate input
`timescale 1ns/100ps
`include "sensor_irq_regs.svh"
module irq_pin_driver
    import sensor_irq_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic [`SRC_COUNT-1:0] i_flags,
    input wire byte_type i_route,
    input wire logic i_alt_sel,
    input wire logic i_pin,
    output logic o_pin,
    output logic o_pin_oe,
    output logic o_alt_in
);
    logic hit;
    logic mapped;
    logic sync1_ff;
    logic sync2_ff;

    assign hit = |(i_flags & i_route[`SRC_COUNT-1:0]);
    assign mapped = |i_route[`SRC_COUNT-1:0];

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pin_oe <= 1'b0;
            o_pin <= 1'b0;
        end
        else if (i_clk_en)
        begin
            // Alternate input function steals the pin from interrupts
            o_pin_oe <= mapped & ~i_alt_sel;
            // Polarity only matters while driving
            if (mapped & ~i_alt_sel)
                o_pin <= hit ^ i_route[`ROUTE_POLARITY_BIT];
            else
                o_pin <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            o_alt_in <= 1'b0;
        end
        else if (i_clk_en)
        begin
            sync1_ff <= i_pin;
            sync2_ff <= sync1_ff;
            o_alt_in <= sync2_ff & i_alt_sel;
        end
    end

    property p_unmapped_release;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && !mapped) |=> !o_pin_oe;
    endproperty
    a_unmapped_release: assert property (p_unmapped_release)
        else $error("unmapped pin is driven");

    property p_alt_release;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && i_alt_sel) |=> (!o_pin_oe && !o_pin);
    endproperty
    a_alt_release: assert property (p_alt_release)
        else $error("pin in alternate use still signals");

    property p_or_level;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && mapped && !i_alt_sel) |=>
            (o_pin_oe && o_pin == ($past(hit) ^ $past(i_route[7])));
    endproperty
    a_or_level: assert property (p_or_level)
        else $error("pin level differs from routed flags");
endmodule : irq_pin_driver

// File: tb/host_pin_model.sv
// Host side of one interrupt pin: keeper, alternate drive, observed level
`timescale 1ns/100ps
module host_pin_model
(
    input wire logic i_dut_pin,
    input wire logic i_dut_oe,
    input wire logic i_host_drive,
    input wire logic i_host_level,
    output logic o_pin
);
    // The pin keeper holds the last level while nobody drives, as on board
    initial o_pin = 1'b0;
    always @(i_dut_pin or i_dut_oe or i_host_drive or i_host_level)
    begin
        if (i_dut_oe)
            o_pin = i_dut_pin;
        else if (i_host_drive)
            o_pin = i_host_level;
    end
endmodule : host_pin_model

// File: tb/sensor_interrupt_logic_tb.sv
// Self-checking bench for the interrupt flags, FIFO flags and pins
`timescale 1ns/100ps
`include "sensor_irq_regs.svh"
module sensor_interrupt_logic_tb
    import sensor_irq_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    byte_type reg_addr = 8'h00;
    byte_type reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic rd_start = 1'b0;
    logic rd_end = 1'b0;
    logic motion_evt = 1'b0;
    logic stillness_evt = 1'b0;
    logic sample_evt = 1'b0;
    logic fifo_push = 1'b0;
    logic fifo_pop = 1'b0;
    logic host_drv_a = 1'b0;
    logic host_drv_b = 1'b0;
    logic host_lvl_a = 1'b0;
    logic host_lvl_b = 1'b0;
    logic pin_a, pin_b, irq_a, irq_a_oe, irq_b, irq_b_oe, ext_in, sync_in;
    byte_type rd_data, flags, got;
    fifo_cnt_type fifo_count;
    logic [1:0] fifo_mode;
    byte_type sample_addrs [3] = '{8'h0a, 8'h0e, 8'h15};
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;

    always #4 ref_clk = ~ref_clk;

    sensor_interrupt_logic dut (.i_ref_clk(ref_clk), .i_rst(rst),
        .i_clk_en(clk_en), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
        .i_reg_wdata(reg_wdata), .i_rd_start(rd_start), .i_rd_end(rd_end),
        .i_motion_evt(motion_evt), .i_stillness_evt(stillness_evt),
        .i_sample_evt(sample_evt), .i_fifo_push(fifo_push),
        .i_fifo_pop(fifo_pop), .i_irq_pin_a(pin_a), .i_irq_pin_b(pin_b),
        .o_rd_data(rd_data), .o_flags(flags), .o_fifo_count(fifo_count),
        .o_fifo_mode(fifo_mode), .o_irq_pin_a(irq_a),
        .o_irq_pin_a_oe(irq_a_oe), .o_irq_pin_b(irq_b),
        .o_irq_pin_b_oe(irq_b_oe), .o_ext_clock_in(ext_in),
        .o_sync_trigger_in(sync_in));

    host_pin_model host_a (.i_dut_pin(irq_a), .i_dut_oe(irq_a_oe),
        .i_host_drive(host_drv_a), .i_host_level(host_lvl_a), .o_pin(pin_a));
    host_pin_model host_b (.i_dut_pin(irq_b), .i_dut_oe(irq_b_oe),
        .i_host_drive(host_drv_b), .i_host_level(host_lvl_b), .o_pin(pin_b));

    task final_report();
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    // Run takes about 670 cycles; the ceiling leaves ample margin
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            final_report();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task step();
        @(posedge ref_clk);
        #1;
    endtask : step

    task wr(input byte_type a, input byte_type d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
        step();
    endtask : wr

    // Opens and closes one read; flags have settled on return
    task rd(input byte_type a, output byte_type d);
        reg_addr = a;
        rd_start = 1'b1;
        step();
        rd_start = 1'b0;
        d = rd_data;
        rd_end = 1'b1;
        step();
        rd_end = 1'b0;
        step();
        step();
    endtask : rd

    task push(input int n);
        fifo_push = 1'b1;
        repeat (n) step();
        fifo_push = 1'b0;
        step();
        step();
    endtask : push

    task pop(input int n);
        fifo_pop = 1'b1;
        repeat (n) step();
        fifo_pop = 1'b0;
        step();
        step();
    endtask : pop

    task pulse_sample();
        sample_evt = 1'b1;
        step();
        sample_evt = 1'b0;
        step();
    endtask : pulse_sample

    initial
    begin
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        check(16'({irq_a_oe, irq_b_oe}), 16'h0000);
        rd(`WMARK_LEVEL_ADDR, got);
        check(16'(got), 16'h0080);
        wr(`PIN_A_ROUTE_ADDR, 8'h80);
        step();
        check(16'(irq_a_oe), 16'h0000);
        wr(`PIN_A_ROUTE_ADDR, 8'h10);
        wr(`PIN_B_ROUTE_ADDR, 8'h30);
        check(16'({irq_a_oe, pin_a, irq_b_oe, pin_b}), 16'h000a);
        motion_evt = 1'b1;
        step();
        motion_evt = 1'b0;
        step();
        check(16'({pin_a, pin_b}), 16'h0003);
        check(16'(flags), 16'h0010);
        rd(`FLAGS_ADDR, got);
        check(16'(got), 16'h0010);
        check(16'({flags, pin_a, pin_b}), 16'h0000);
        stillness_evt = 1'b1;
        step();
        stillness_evt = 1'b0;
        step();
        check(16'({flags, pin_a, pin_b}), 16'h0081);
        rd(`FLAGS_ADDR, got);
        check(16'(got), 16'h0020);
        wr(`PIN_B_ROUTE_ADDR, 8'hb0);
        check(16'({irq_b_oe, pin_b}), 16'h0003);
        motion_evt = 1'b1;
        step();
        motion_evt = 1'b0;
        step();
        check(16'({irq_b_oe, pin_b}), 16'h0002);
        rd(`FLAGS_ADDR, got);
        wr(`FLAGS_ADDR, 8'hff);
        rd(`FLAGS_ADDR, got);
        check(16'(got), 16'h0000);
        wr(`PIN_A_ROUTE_ADDR, 8'h01);
        pulse_sample();
        check(16'({flags, pin_a}), 16'h0003);
        // A sample arriving mid-read must wait for the read to close
        reg_addr = `SAMPLE_LO_FIRST_ADDR;
        rd_start = 1'b1;
        step();
        rd_start = 1'b0;
        step();
        check(16'(flags), 16'h0000);
        pulse_sample();
        step();
        check(16'({flags, pin_a}), 16'h0000);
        rd_end = 1'b1;
        step();
        rd_end = 1'b0;
        step();
        check(16'({flags, pin_a}), 16'h0003);
        foreach (sample_addrs[i])
        begin
            pulse_sample();
            rd(sample_addrs[i], got);
            check(16'(flags), 16'h0000);
        end
        wr(`PIN_A_ROUTE_ADDR, 8'h00);
        wr(`FIFO_CONTROL_ADDR, 8'h01);
        wr(`WMARK_LEVEL_ADDR, 8'h03);
        push(2);
        check(16'(flags), 16'h0002);
        push(1);
        check(32'({fifo_count, flags}), 32'h00000306);
        pop(1);
        check(32'({fifo_count, flags}), 32'h00000202);
        pop(2);
        check(16'(flags), 16'h0000);
        wr(`WMARK_LEVEL_ADDR, 8'h00);
        step();
        check(16'(flags), 16'h0004);
        wr(`FIFO_CONTROL_ADDR, 8'h09);
        check(16'(fifo_mode), 16'h0001);
        wr(`PIN_A_ROUTE_ADDR, 8'h08);
        push(255);
        check(16'(flags), 16'h0002);
        push(1);
        check(32'({fifo_count, flags}), 32'h00010006);
        push(256);
        check(32'({fifo_count, flags, pin_a}), 32'h0004000c);
        push(1);
        check(32'({fifo_count, flags, pin_a}), 32'h0004001d);
        pop(1);
        check(32'({fifo_count, flags, pin_a}), 32'h0003fe0c);
        push(2);
        check(16'(flags), 16'h000e);
        wr(`FIFO_CONTROL_ADDR, 8'h00);
        step();
        check(32'({fifo_mode, fifo_count, flags}), 32'h00000000);
        push(1);
        check(32'({fifo_count, flags}), 32'h00000000);
        wr(`PIN_A_ROUTE_ADDR, 8'h3f);
        wr(`PIN_B_ROUTE_ADDR, 8'h3f);
        motion_evt = 1'b1;
        step();
        motion_evt = 1'b0;
        step();
        wr(`POWER_CONTROL_ADDR, 8'h40);
        check(16'({irq_a_oe, irq_b_oe, pin_b}), 16'h0003);
        host_drv_a = 1'b1;
        host_lvl_a = 1'b0;
        repeat (5) step();
        check(16'(ext_in), 16'h0000);
        host_lvl_a = 1'b1;
        repeat (5) step();
        check(16'(ext_in), 16'h0001);
        wr(`FILTER_CONTROL_ADDR, 8'h08);
        check(16'({irq_a_oe, irq_b_oe}), 16'h0000);
        host_drv_b = 1'b1;
        host_lvl_b = 1'b1;
        repeat (5) step();
        check(16'({sync_in, ext_in}), 16'h0003);
        host_drv_a = 1'b0;
        wr(`POWER_CONTROL_ADDR, 8'h00);
        check(16'({irq_a_oe, pin_a, ext_in}), 16'h0006);
        // A read while the clock enable is low must not clear anything
        clk_en = 1'b0;
        rd(`FLAGS_ADDR, got);
        clk_en = 1'b1;
        step();
        step();
        check(16'(flags), 16'h0010);
        final_report();
    end
endmodule : sensor_interrupt_logic_tb
